// File: hw/smb_core.sv
`timescale 1ns/1ps
// Behaviour
// - Software moves whole bytes; hardware sequences every bit on its own.
// - Serial rate may reach one twentieth of the system clock, master or slave.
// - The SCL low period can be lengthened for slower devices.
// - Works as master, slave or both; arbitration resolves multi-master contention.
// - Software or hardware may accept the slave address and produce acknowledges.
// - With free timeout enabled, bus is free after >10 source periods both high.
// - A pending master START goes out right after the free timeout.
// - Free timeout detection needs the bit-rate source, even slave-only.
// - SCL is generated only as master; SDA follows SCL in both roles.
// - An interrupt is raised for every data byte and slave address byte, except an unmatched address with hardware ack on.
// - Hardware ack off, transmitting: byte interrupt comes after the ACK cycle.
// - Hardware ack off, receiving: byte interrupt comes before the ACK cycle.
// - Hardware ack on: every byte interrupt comes after the ACK cycle.
// - Interrupt also on master START generated and on slave STOP detected.
// - Enable bit allows all master and slave events; clear means no bus activity.
// - Inhibited slave still watches the bus, NACKs addresses, raises no slave interrupts.
// - Slave inhibit acts from the next START; current transfer finishes normally.
// - START and STOP generated and detected; timeouts recognised; status reported.
// - Configuration enables roles, selects bit-rate source, timing and timeout options.
module smb_core
    import smb_pkg::*;
#(
    parameter int unsigned SCL_LOW_TIMEOUT_CYCLES = SCL_LOW_TIMEOUT_CYCLES_DEF,
    parameter logic [3:0] LOW_TICKS = LOW_TICKS_DEF,
    parameter logic [3:0] HIGH_TICKS = HIGH_TICKS_DEF,
    parameter logic [3:0] EXTEND_TICKS = EXTEND_TICKS_DEF
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_clk_src_tick,
    input wire logic i_enable,
    input wire logic i_slave_inhibit,
    input wire logic i_free_timeout_enable,
    input wire logic i_scl_low_timeout_enable,
    input wire logic i_scl_low_extend,
    input wire logic i_hw_ack_enable,
    input wire logic [6:0] i_own_addr,
    input wire logic i_start_req,
    input wire logic i_stop_req,
    input wire logic [7:0] i_tx_data,
    input wire logic i_ack_out,
    input wire logic i_si_clear,
    output logic o_scl_out,
    output logic o_scl_oe,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_si,
    output logic [1:0] o_cause,
    output logic o_master,
    output logic o_slave_active,
    output logic o_tx_mode,
    output logic o_rx_ack,
    output logic [7:0] o_rx_data,
    output logic o_arb_lost,
    output logic o_bus_busy,
    output logic o_scl_low_timeout
);

    localparam int LT_W = $clog2(SCL_LOW_TIMEOUT_CYCLES + 1);

    logic scl_s1, scl_s2, scl_d;
    logic sda_s1, sda_s2, sda_d;
    logic [3:0] free_cnt;
    logic [LT_W-1:0] low_cnt;
    smb_mst_t mst_state;
    logic [3:0] bit_cnt;
    logic [3:0] hcnt;
    logic [7:0] hcyc;
    logic addr_phase;
    logic ack_sent;
    logic rw_bit;
    logic [3:0] low_need;
    logic low_done, high_done;
    logic scl_rise, scl_fall, start_det, stop_det;
    logic addr_match, taking_part;

    // Two-stage synchronisers; the second stage and its one-cycle delayed copy feed logic
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_s1 <= LINE_IDLE;
            scl_s2 <= LINE_IDLE;
            scl_d <= LINE_IDLE;
            sda_s1 <= LINE_IDLE;
            sda_s2 <= LINE_IDLE;
            sda_d <= LINE_IDLE;
        end else begin
            scl_s1 <= i_scl;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= i_sda;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end

    assign scl_rise = scl_s2 && !scl_d;
    assign scl_fall = !scl_s2 && scl_d;
    assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
    assign addr_match = (o_rx_data[7:1] == i_own_addr);
    assign taking_part = o_master || o_slave_active;

    // Low phase is stretched on request for slow devices
    assign low_need = i_scl_low_extend ? 4'(LOW_TICKS + EXTEND_TICKS) : LOW_TICKS;
    // The cycle floor keeps each half period at least half of the fastest bit time
    assign low_done = (hcnt >= low_need) && (hcyc >= HALF_MIN_CYCLES);
    assign high_done = (hcnt >= HIGH_TICKS) && (hcyc >= HALF_MIN_CYCLES);

    // Bus-free detection counts source ticks, so it stalls with no bit-rate source
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            free_cnt <= 4'h0;
            o_bus_busy <= 1'h0;
        end else begin
            if (!(scl_s2 && sda_s2)) begin
                free_cnt <= 4'h0;
            end else if (i_clk_src_tick && free_cnt != FREE_CNT_MAX) begin
                free_cnt <= free_cnt + 4'h1;
            end
            if (start_det) begin
                o_bus_busy <= 1'h1;
            end else if (stop_det) begin
                o_bus_busy <= 1'h0;
            end else if (i_free_timeout_enable && free_cnt == FREE_CNT_MAX) begin
                o_bus_busy <= 1'h0;
            end
        end
    end

    // SCL low timeout flag; recovery is left to software by re-enabling
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_cnt <= '0;
            o_scl_low_timeout <= 1'h0;
        end else begin
            if (scl_s2 || !i_scl_low_timeout_enable) begin
                low_cnt <= '0;
            end else if (low_cnt != LT_W'(SCL_LOW_TIMEOUT_CYCLES)) begin
                low_cnt <= low_cnt + LT_W'(1);
            end
            if (!i_enable) begin
                o_scl_low_timeout <= 1'h0;
            end else if (low_cnt == LT_W'(SCL_LOW_TIMEOUT_CYCLES - 1)) begin
                o_scl_low_timeout <= 1'h1;
            end
        end
    end

    // Lines are only ever pulled low, never driven high
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_scl_out <= 1'h0;
            o_sda_out <= 1'h0;
        end else begin
            o_scl_out <= 1'h0;
            o_sda_out <= 1'h0;
        end
    end

    // Protocol engine: master sequencing, byte shifting, acknowledge and interrupts
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mst_state <= M_IDLE;
            o_master <= 1'h0;
            o_slave_active <= 1'h0;
            o_tx_mode <= 1'h0;
            o_scl_oe <= 1'h0;
            o_sda_oe <= 1'h0;
            o_si <= 1'h0;
            o_cause <= CAUSE_BYTE;
            o_rx_ack <= 1'h0;
            o_rx_data <= 8'h00;
            o_arb_lost <= 1'h0;
            bit_cnt <= BIT_FIRST;
            hcnt <= 4'h0;
            hcyc <= 8'h00;
            addr_phase <= 1'h0;
            ack_sent <= 1'h0;
            rw_bit <= 1'h0;
        end else if (!i_enable) begin
            mst_state <= M_IDLE;
            o_master <= 1'h0;
            o_slave_active <= 1'h0;
            o_tx_mode <= 1'h0;
            o_scl_oe <= 1'h0;
            o_sda_oe <= 1'h0;
            o_si <= 1'h0;
            bit_cnt <= BIT_FIRST;
            addr_phase <= 1'h0;
        end else begin
            if (i_clk_src_tick && hcnt != 4'hF) begin
                hcnt <= hcnt + 4'h1;
            end
            if (hcyc != 8'hFF) begin
                hcyc <= hcyc + 8'h01;
            end

            // Software hands over the next byte, ack value, STOP or repeated START
            if (i_si_clear && o_si) begin
                o_si <= 1'h0;
                if (o_master && o_cause == CAUSE_BYTE && bit_cnt == BIT_FIRST && i_stop_req) begin
                    mst_state <= M_STOP_A;
                    o_sda_oe <= 1'h1;
                    hcnt <= 4'h0;
                    hcyc <= 8'h00;
                end else if (o_master && o_cause == CAUSE_BYTE && bit_cnt == BIT_FIRST && i_start_req) begin
                    mst_state <= M_RESTART_A;
                    o_sda_oe <= 1'h0;
                    hcnt <= 4'h0;
                    hcyc <= 8'h00;
                end else if (bit_cnt == BIT_ACK) begin
                    o_sda_oe <= i_ack_out;
                    ack_sent <= i_ack_out;
                    if (addr_phase && !o_master && rw_bit) begin
                        o_rx_data <= i_tx_data;
                    end
                end else if (o_tx_mode) begin
                    o_rx_data <= i_tx_data;
                    o_sda_oe <= !i_tx_data[7];
                end else begin
                    o_sda_oe <= 1'h0;
                end
            end

            case (mst_state)
                M_IDLE: begin
                    if (i_start_req && !o_bus_busy && !o_si && !o_slave_active) begin
                        mst_state <= M_START;
                        o_master <= 1'h1;
                        o_arb_lost <= 1'h0;
                        o_sda_oe <= 1'h1;
                        hcnt <= 4'h0;
                        hcyc <= 8'h00;
                    end
                end
                M_START: begin
                    if (high_done) begin
                        mst_state <= M_RUN;
                        o_scl_oe <= 1'h1;
                        o_si <= 1'h1;
                        o_cause <= CAUSE_START;
                        hcnt <= 4'h0;
                        hcyc <= 8'h00;
                    end
                end
                M_RUN: begin
                    // SCL stays low while an interrupt is pending
                    if (o_scl_oe) begin
                        if (!o_si && low_done) begin
                            o_scl_oe <= 1'h0;
                            hcnt <= 4'h0;
                            hcyc <= 8'h00;
                        end
                    end else if (!scl_s2) begin
                        // Another device holds SCL low: restart the high count
                        hcnt <= 4'h0;
                        hcyc <= 8'h00;
                    end else if (high_done) begin
                        o_scl_oe <= 1'h1;
                        hcnt <= 4'h0;
                        hcyc <= 8'h00;
                    end
                end
                M_STOP_A, M_RESTART_A: begin
                    if (low_done) begin
                        mst_state <= (mst_state == M_STOP_A) ? M_STOP_B : M_RESTART_B;
                        o_scl_oe <= 1'h0;
                        hcnt <= 4'h0;
                        hcyc <= 8'h00;
                    end
                end
                M_STOP_B, M_RESTART_B: begin
                    if (!scl_s2) begin
                        hcnt <= 4'h0;
                        hcyc <= 8'h00;
                    end else if (high_done) begin
                        hcnt <= 4'h0;
                        hcyc <= 8'h00;
                        if (mst_state == M_STOP_B) begin
                            mst_state <= M_IDLE;
                            o_sda_oe <= 1'h0;
                            o_master <= 1'h0;
                        end else begin
                            mst_state <= M_START;
                            o_sda_oe <= 1'h1;
                        end
                    end
                end
                default: mst_state <= M_IDLE;
            endcase

            // A slave stretches SCL low while software handles its interrupt
            if (o_slave_active && !o_master) begin
                o_scl_oe <= o_si;
            end

            if (start_det) begin
                bit_cnt <= BIT_FIRST;
                addr_phase <= 1'h1;
                if (o_master) begin
                    o_tx_mode <= 1'h1;
                end else begin
                    o_tx_mode <= 1'h0;
                    // Inhibit is sampled only here, so a running transfer completes
                    o_slave_active <= !i_slave_inhibit;
                end
            end else if (stop_det) begin
                if (o_slave_active && !addr_phase) begin
                    o_si <= 1'h1;
                    o_cause <= CAUSE_STOP;
                end
                o_slave_active <= 1'h0;
                bit_cnt <= BIT_FIRST;
                if (!o_master) begin
                    o_tx_mode <= 1'h0;
                    o_sda_oe <= 1'h0;
                    o_scl_oe <= 1'h0;
                end
            end else if (taking_part && scl_rise) begin
                if (bit_cnt < BIT_ACK) begin
                    if (o_master && o_tx_mode && !o_sda_oe && !sda_s2) begin
                        mst_state <= M_IDLE;
                        o_master <= 1'h0;
                        o_tx_mode <= 1'h0;
                        o_scl_oe <= 1'h0;
                        o_sda_oe <= 1'h0;
                        o_arb_lost <= 1'h1;
                        o_si <= 1'h1;
                        o_cause <= CAUSE_ARB;
                        bit_cnt <= BIT_FIRST;
                    end else begin
                        o_rx_data <= {o_rx_data[6:0], sda_s2};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end else begin
                    o_rx_ack <= !sda_s2;
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (taking_part && scl_fall) begin
                if (bit_cnt == BIT_ACK) begin
                    rw_bit <= o_rx_data[0];
                    if (o_tx_mode) begin
                        o_sda_oe <= 1'h0;
                    end else if (!i_hw_ack_enable) begin
                        o_si <= 1'h1;
                        o_cause <= CAUSE_BYTE;
                    end else if (addr_phase && !o_master) begin
                        o_sda_oe <= addr_match;
                        ack_sent <= addr_match;
                    end else begin
                        o_sda_oe <= i_ack_out;
                        ack_sent <= i_ack_out;
                    end
                end else if (bit_cnt == BIT_DONE) begin
                    bit_cnt <= BIT_FIRST;
                    if (!o_tx_mode) begin
                        o_sda_oe <= 1'h0;
                    end
                    if (addr_phase && !o_master && !ack_sent) begin
                        o_slave_active <= 1'h0;
                        addr_phase <= 1'h0;
                    end else begin
                        addr_phase <= 1'h0;
                        if (o_tx_mode || i_hw_ack_enable) begin
                            o_si <= 1'h1;
                            o_cause <= CAUSE_BYTE;
                        end
                        if (addr_phase && o_master) begin
                            o_tx_mode <= !rw_bit;
                        end else if (addr_phase) begin
                            o_tx_mode <= rw_bit;
                            if (rw_bit && !i_hw_ack_enable) begin
                                o_sda_oe <= !o_rx_data[7];
                            end
                        end
                    end
                end else if (bit_cnt != BIT_FIRST && o_tx_mode) begin
                    o_sda_oe <= !o_rx_data[7];
                end
            end
        end
    end

    AST_DISABLE_RELEASES: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_enable |=> !o_scl_oe && !o_sda_oe && !o_master && !o_si)
        else $error("interface still active while disabled");

    AST_START_IRQ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_enable && mst_state == M_START && high_done && !start_det && !stop_det && !scl_rise && !scl_fall)
        |=> o_si && o_cause == CAUSE_START && o_scl_oe && o_sda_oe)
        else $error("START not followed by start interrupt with both lines low");

    AST_FREE_TIMEOUT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_free_timeout_enable && scl_s2 && sda_s2 && free_cnt == FREE_TIMEOUT_PERIODS && i_clk_src_tick)
        ##1 (scl_s2 && sda_s2 && !start_det)[*2] |-> !o_bus_busy)
        else $error("bus not freed after high timeout");

    AST_INHIBIT_NO_SLAVE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_enable && start_det && !o_master && i_slave_inhibit) |=> !o_slave_active)
        else $error("inhibited interface took part as slave");

    AST_ARB_RELEASE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(o_arb_lost) |-> !o_master && !o_scl_oe && !o_sda_oe && o_si && o_cause == CAUSE_ARB)
        else $error("lost arbitration but lines not released");

    AST_RX_BEFORE_ACK: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ($rose(o_si) && o_cause == CAUSE_BYTE && !$past(o_tx_mode) && !i_hw_ack_enable)
        |-> bit_cnt == BIT_ACK)
        else $error("receive interrupt not raised before the ACK slot");

    AST_TX_AFTER_ACK: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ($rose(o_si) && o_cause == CAUSE_BYTE && ($past(o_tx_mode) || $past(i_hw_ack_enable)))
        |-> bit_cnt == BIT_FIRST)
        else $error("byte interrupt not raised after the ACK slot");

    AST_SLAVE_STRETCH: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_enable && o_si && o_slave_active && !o_master && !i_si_clear && !stop_det && !start_det)
        |=> o_scl_oe)
        else $error("slave did not hold SCL low during pending interrupt");

    AST_NO_SCL_IDLE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!o_master && !o_slave_active) ##1 (!o_master && !o_slave_active) |-> !o_scl_oe)
        else $error("SCL driven while neither master nor slave");

    AST_HALF_MIN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (mst_state == M_RUN && $rose(o_scl_oe)) |-> $past(hcyc) >= HALF_MIN_CYCLES || $past(o_si)
            || $past(mst_state) != M_RUN)
        else $error("SCL high half period shorter than the minimum");

endmodule

// File: hw/smb_pkg.sv
package smb_pkg;

    // System clock period, in ns
    localparam int SYS_CLK_PERIOD_NS = 10;
    // Fastest serial rate is the system clock divided by this figure
    localparam int MAX_RATE_DIVISOR = 20;
    // Least length of each SCL half period, in system clock cycles
    localparam logic [7:0] HALF_MIN_CYCLES = 8'(MAX_RATE_DIVISOR / 2);

    // Bus counts as free after more than this many bit-rate source periods high
    localparam logic [3:0] FREE_TIMEOUT_PERIODS = 4'hA;
    localparam logic [3:0] FREE_CNT_MAX = FREE_TIMEOUT_PERIODS + 4'h1;

    // SCL low timeout, in ms, and its default length in system clock cycles
    localparam int SCL_LOW_TIMEOUT_MS = 25;
    localparam int SCL_LOW_TIMEOUT_CYCLES_DEF = SCL_LOW_TIMEOUT_MS * (1000000 / SYS_CLK_PERIOD_NS);

    // Default master half-period lengths in bit-rate source periods
    localparam logic [3:0] LOW_TICKS_DEF = 4'h1;
    localparam logic [3:0] HIGH_TICKS_DEF = 4'h1;
    localparam logic [3:0] EXTEND_TICKS_DEF = 4'h2;

    // Bit counter positions within a byte slot
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_DONE = 4'h9;

    // Interrupt cause codes
    localparam logic [1:0] CAUSE_BYTE = 2'h0;
    localparam logic [1:0] CAUSE_START = 2'h1;
    localparam logic [1:0] CAUSE_STOP = 2'h2;
    localparam logic [1:0] CAUSE_ARB = 2'h3;

    // Reset level of a released bus line as seen through the synchroniser
    localparam logic LINE_IDLE = 1'h1;

    typedef enum logic [2:0] {
        M_IDLE,
        M_START,
        M_RUN,
        M_STOP_A,
        M_STOP_B,
        M_RESTART_A,
        M_RESTART_B
    } smb_mst_t;

endpackage

// File: testbench/smb_bus_partner.sv
`timescale 1ns/1ps
module smb_bus_partner (
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_ack_en,
    input wire logic i_stretch,
    output logic o_scl_low = 1'b0,
    output logic o_sda_low = 1'b0,
    output logic [7:0] o_byte = 8'h00
);
    int nbit = 0;
    // A START restarts the bit count
    always @(negedge i_sda) if (i_scl) nbit = 0;
    always @(posedge i_scl) begin
        if (nbit < 8) o_byte = {o_byte[6:0], i_sda};
        nbit++;
    end
    // Only ever pulls low; a released line floats back to the pull-up level
    always @(negedge i_scl) begin
        o_sda_low = i_ack_en && nbit == 8;
        if (nbit == 9) nbit = 0;
        if (i_stretch) begin
            o_scl_low = 1'b1;
            #300 o_scl_low = 1'b0;
        end
    end
endmodule

// File: testbench/smbus_master_slave_interface_tb_top.sv
`timescale 1ns/1ps
module smbus_master_slave_interface_tb_top;
    import smb_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, en = 1'b0, slave_inhibit_bit = 1'b0, fte = 1'b1, tmo_en = 1'b1;
    logic ext = 1'b0, start = 1'b0, stop = 1'b0, clr = 1'b0, ms_scl = 1'b0, ms_sda = 1'b0;
    logic p_ack = 1'b0, p_str = 1'b0, scl_oe, sda_oe, p_scl, p_sda, si, master, busy, rx_ack, low_to;
    logic [1:0] cause;
    logic hwa = 1'b1, scl_o, sda_o, arb_lost, slv, txm;
    logic [7:0] txd = 8'h00, p_byte, rxd;
    int fails = 0, n_tests = 0, cyc = 0;
    wire scl = !(scl_oe | p_scl | ms_scl);
    wire sda = !(sda_oe | p_sda | ms_sda);
    always #5 clk = !clk;
    always @(negedge clk) begin
        cyc++;
        tick = (cyc % 8 == 0);
    end
    smb_core #(.SCL_LOW_TIMEOUT_CYCLES(200)) DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
        .i_clk_src_tick(tick), .i_enable(en), .i_slave_inhibit(slave_inhibit_bit), .i_free_timeout_enable(fte),
        .i_scl_low_timeout_enable(tmo_en), .i_scl_low_extend(ext), .i_hw_ack_enable(hwa),
        .i_own_addr(7'h2A), .i_start_req(start), .i_stop_req(stop), .i_tx_data(txd), .i_ack_out(1'b1),
        .i_si_clear(clr), .o_scl_out(scl_o), .o_scl_oe(scl_oe), .o_sda_out(sda_o), .o_sda_oe(sda_oe),
        .o_si(si), .o_cause(cause), .o_master(master), .o_slave_active(slv), .o_tx_mode(txm),
        .o_rx_ack(rx_ack), .o_rx_data(rxd), .o_arb_lost(arb_lost), .o_bus_busy(busy),
        .o_scl_low_timeout(low_to));
    smb_bus_partner PART (.i_scl(scl), .i_sda(sda), .i_ack_en(p_ack), .i_stretch(p_str),
        .o_scl_low(p_scl), .o_sda_low(p_sda), .o_byte(p_byte));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_si;
        for (int i = 0; i < 9000 && si !== 1'b1; i++) tk(1);
        if (si !== 1'b1) begin
            fails++;
            $display("Error at %0t: interrupt wait ran out", $time);
            give_verdict;
        end
    endtask
    task automatic release_si(input logic [7:0] d, input logic s);
        txd = d;
        stop = s;
        clr = 1'b1;
        tk(1);
        clr = 1'b0;
    endtask
    // Slow run: partner stretches SCL and the low phase is lengthened
    task automatic t_master(input logic slow, input logic [7:0] addr);
        p_ack = 1'b1;
        p_str = slow;
        ext = slow;
        start = 1'b1;
        wait_si;
        check(cause, CAUSE_START);
        start = 1'b0;
        release_si(addr, 1'b0);
        wait_si;
        check(cause, CAUSE_BYTE);
        check(rx_ack, 1'b1);
        check(p_byte, addr);
        check(txm, 1'b1);
        check({scl_o, sda_o}, 2'b00);
        release_si(8'h00, 1'b1);
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) tk(1);
        check({master, busy, scl_oe, sda_oe}, 4'h0);
        p_ack = 1'b0;
        p_str = 1'b0;
        $display("Master write %h done", addr);
    endtask
    // Bench acts as master at the fastest documented rate, 20 clocks a bit
    task automatic bb_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= -1; i--) begin
            ms_sda = (i >= 0) ? !b[i] : 1'b0;
            if (i < 0) begin
                // Without hardware ack the receiver is interrupted before the ack slot
                check(si, !hwa && !slave_inhibit_bit);
                if (si === 1'b1) release_si(8'h00, 1'b0);
            end
            tk(7);
            ms_scl = 1'b0;
            ack = sda;
            tk(10);
            ms_scl = 1'b1;
            tk(3);
        end
    endtask
    task automatic t_slave(input logic inhibit);
        logic ack;
        slave_inhibit_bit = inhibit;
        ms_sda = 1'b1;
        tk(10);
        ms_scl = 1'b1;
        tk(3);
        bb_byte(8'h54, ack);
        check(ack, inhibit);
        check(slv, !inhibit);
        tk(5);
        check(si, !inhibit && hwa);
        if (!inhibit) begin
            check(cause, CAUSE_BYTE);
            check(rxd, 8'h54);
            release_si(8'h00, 1'b0);
            slave_inhibit_bit = 1'b1;
            ms_sda = 1'b1;
            tk(3);
            ms_scl = 1'b0;
            tk(10);
            ms_sda = 1'b0;
            tk(6);
            check({si, cause}, {1'b1, CAUSE_STOP});
            release_si(8'h00, 1'b0);
        end else begin
            // Both lines rise together, so no STOP is seen and only the free timeout ends busy
            ms_sda = 1'b1;
            tk(3);
            ms_scl = 1'b0;
            ms_sda = 1'b0;
            start = 1'b1;
            tk(40);
            check({busy, master}, 2'b10);
            t_master(1'b0, 8'h3A);
        end
        $display("Slave pass done, inhibit %b", inhibit);
    endtask
    // Bench holds SDA low while the interface sends a 1, so the interface must back off
    task automatic t_arb;
        start = 1'b1;
        wait_si;
        start = 1'b0;
        ms_sda = 1'b1;
        release_si(8'hA4, 1'b0);
        wait_si;
        check({cause, arb_lost, master}, {CAUSE_ARB, 2'b10});
        ms_sda = 1'b0;
        tk(20);
        check({busy, scl_oe, sda_oe}, 3'h0);
        release_si(8'h00, 1'b0);
        $display("Arbitration pass done");
    endtask
    task automatic t_idle;
        ms_scl = 1'b1;
        tk(250);
        check(low_to, 1'b1);
        en = 1'b0;
        start = 1'b1;
        tk(2);
        check({low_to, scl_oe, sda_oe}, 3'h0);
        ms_scl = 1'b0;
        tk(100);
        check({master, scl_oe}, 2'h0);
        $display("Disable pass done");
    endtask
    initial begin
        tk(2);
        rst_n = 1'b1;
        en = 1'b1;
        t_master(1'b0, 8'hA4);
        t_arb;
        t_master(1'b1, 8'h3A);
        t_slave(1'b0);
        t_slave(1'b1);
        hwa = 1'b0;
        t_slave(1'b0);
        t_idle;
        give_verdict;
    end
endmodule
